/* File: src/adc_seq_pkg.sv */
// Constants, field layout and carrier types for the conversion sequencer.
// Assumes a 32-bit AHB-Lite register bus and one system clock.
package adc_seq_pkg;

    // ========================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_CTRL2 = 8'h08;
    localparam logic [7:0] OFS_PINSEL = 8'h0C;
    localparam logic [7:0] OFS_IRQ = 8'h10;
    localparam logic [7:0] OFS_RESULT = 8'h14;

    // ========================================
    // Field positions
    localparam int CTRL0_START = 7;
    localparam int CTRL0_BUSY = 6;
    localparam int CTRL0_POWER = 5;
    localparam int CTRL0_FORMAT = 4;
    localparam int CTRL0_CH_LSB = 0;
    localparam int CTRL1_SRC_LSB = 5;
    localparam int CTRL1_DIV_LSB = 0;
    localparam int CTRL2_REF_LSB = 0;
    localparam int PINSEL_EXTREF = 8;
    localparam int PINSEL_REFOUT = 9;
    localparam int IRQ_GLOBAL = 0;
    localparam int IRQ_ENABLE = 1;
    localparam int IRQ_FLAG = 2;
    localparam int IRQ_STACK_FULL = 3;

    // ========================================
    // Reset values and timing
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [2:0] SRC_EXTERNAL = 3'h0;
    localparam logic [3:0] SAMPLE_CLKS = 4'h4;
    localparam logic [3:0] CONVERT_CLKS = 4'hC;
    localparam int RESULT_BITS = 12;

    // ========================================
    // Reference routing as seen by the analog side
    typedef enum logic [1:0] {
        REF_SUPPLY = 2'b00,
        REF_EXT_PIN = 2'b01,
        REF_BANDGAP = 2'b10
    } ref_src_e;

    typedef struct packed {
        logic power;
        logic sample;
        logic ext_connect;
        logic [2:0] channel;
        logic [2:0] source;
        ref_src_e ref_src;
        logic [1:0] ref_gain_m1;
        logic ref_out_en;
        logic [11:0] dac_code;
    } ana_ctrl_s;

endpackage

/* File: src/sar_engine.sv */
// Successive approximation sequencer: 4 sampling plus 12 bit-trial
// converter clocks. Assumes tick is a one-cycle strobe per converter clock.
`timescale 1ns/1ns
`default_nettype none
module sar_engine
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Control
    input wire logic tick,
    input wire logic go,
    input wire logic abort,
    input wire logic comp_high,
    // Status
    output logic sampling,
    output logic busy,
    output logic done,
    output logic [RESULT_BITS-1:0] trial,
    output logic [RESULT_BITS-1:0] result
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10
    } sar_state_e;

    sar_state_e state;
    logic [3:0] count;
    logic [RESULT_BITS-1:0] mask;

    // ========================================
    // Sequencing
    always_ff @(posedge clock) begin
        done <= 1'b0;
        if (sys_rst || abort) begin
            state <= ST_IDLE;
            count <= 4'h0;
            mask <= '0;
            trial <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (go) begin
                        state <= ST_SAMPLE;
                        count <= 4'h0;
                    end
                end
                ST_SAMPLE: begin
                    if (tick) begin
                        count <= count + 4'h1;
                        if (count == SAMPLE_CLKS - 4'h1) begin
                            state <= ST_CONVERT;
                            count <= 4'h0;
                            mask <= 12'h800;
                            trial <= 12'h800;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (tick) begin
                        count <= count + 4'h1;
                        // Comparator high: input above trial, keep bit
                        trial <= (comp_high ? trial : trial & ~mask)
                                 | (mask >> 1);
                        mask <= mask >> 1;
                        if (count == CONVERT_CLKS - 4'h1) begin
                            state <= ST_IDLE;
                            done <= 1'b1;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Unsigned code, all ones at full scale
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            result <= '0;
        end else if (state == ST_CONVERT && tick
                     && count == CONVERT_CLKS - 4'h1) begin
            result <= comp_high ? trial : trial & ~mask;
        end
    end

    assign sampling = (state == ST_SAMPLE);
    assign busy = (state != ST_IDLE);

endmodule
`default_nettype wire

/* File: src/adc_conversion_sequencer.sv */
// Control logic of a 12-bit SAR converter: registers, clock divider,
// pin sharing, sequencing and completion request.
// Assumes an AHB-Lite master with one slave and a comparator input.
//
// What this block does
// - Analog-selected pin loses all other functions
// - Pull-high dropped while pin is analog
// - Port direction ignored on analog pins
// - Sample four clocks, convert twelve clocks
// - Conversion runs autonomously without stalling CPU
// - Busy high during conversion, results then valid
// - Request only when enabled, stack not full
// - Power bit one powers up converter
// - Power bit zero switches analog off
// - Source field picks pin or internal
// - Channel field picks external analog pin
// - Reference field picks supply, pin, bandgap
// - Format bit aligns result across bytes
// - Unsigned twelve-bit result, reference over 4096
// - Divider codes are powers of two
// - Completion always sets request flag
// - Reference code map with gains
// - Global enable low blocks the request
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_sequencer
    import adc_seq_pkg::*;
#(
    parameter int PINS = 8
)(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Port logic requests per pin
    input wire logic [PINS-1:0] gpio_dout,
    input wire logic [PINS-1:0] port_direction_ctrl,
    input wire logic [PINS-1:0] pull_high_req,
    output logic [PINS-1:0] pad_dout,
    output logic [PINS-1:0] pad_oe,
    output logic [PINS-1:0] pad_pull_en,
    output logic [PINS-1:0] analog_sw_en,
    // Analog core
    input wire logic comp_high,
    output ana_ctrl_s ana_ctrl,
    // Interrupt controller
    input wire logic stack_full,
    input wire logic irq_ack,
    output logic conv_irq_req
);

    // ========================================
    // Elaboration checks
    if (PINS < 1 || PINS > 8) begin : g_bad_pins
        $error("PINS must be 1 to 8");
    end

    logic start_bit;
    logic conv_power_en;
    logic result_format_sel;
    logic [2:0] ext_channel_sel;
    logic [2:0] input_source_sel;
    logic [2:0] conv_clk_div_sel;
    logic [3:0] ref_source_sel;
    logic [PINS-1:0] pin_function_select;
    logic ext_ref_input;
    logic ref_output_pin;
    logic global_irq_en;
    logic conv_irq_en;
    logic conv_irq_flag;
    logic [7:0] result_high;
    logic [7:0] result_low;

    logic pend;
    logic pend_write;
    logic [7:0] pend_addr;
    logic do_write;
    logic [31:0] read_word;

    logic start_prev;
    logic go;
    logic abort;
    logic [6:0] div_count;
    logic tick;
    logic sampling;
    logic busy;
    logic done;
    logic [11:0] trial;
    logic [11:0] code;
    logic ext_selected;

    // ========================================
    // Bus slave: one wait state on every transfer
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pend <= 1'b0;
            pend_write <= 1'b0;
            pend_addr <= 8'h00;
            hreadyout <= 1'b1;
        end else if (hsel && htrans[1] && hready && hreadyout) begin
            pend <= 1'b1;
            pend_write <= hwrite;
            pend_addr <= haddr[7:0];
            hreadyout <= 1'b0;
        end else begin
            pend <= 1'b0;
            hreadyout <= 1'b1;
        end
    end

    // Only OKAY responses
    always_ff @(posedge clock) begin
        hresp <= 1'b0;
    end

    assign do_write = pend && pend_write;

    always_comb begin
        read_word = RESET_WORD;
        unique case (pend_addr)
            OFS_CTRL0: begin
                read_word[CTRL0_START] = start_bit;
                read_word[CTRL0_BUSY] = busy;
                read_word[CTRL0_POWER] = conv_power_en;
                read_word[CTRL0_FORMAT] = result_format_sel;
                read_word[CTRL0_CH_LSB +: 3] = ext_channel_sel;
            end
            OFS_CTRL1: begin
                read_word[CTRL1_SRC_LSB +: 3] = input_source_sel;
                read_word[CTRL1_DIV_LSB +: 3] = conv_clk_div_sel;
            end
            OFS_CTRL2: read_word[CTRL2_REF_LSB +: 4] = ref_source_sel;
            OFS_PINSEL: begin
                read_word[PINS-1:0] = pin_function_select;
                read_word[PINSEL_EXTREF] = ext_ref_input;
                read_word[PINSEL_REFOUT] = ref_output_pin;
            end
            OFS_IRQ: begin
                read_word[IRQ_GLOBAL] = global_irq_en;
                read_word[IRQ_ENABLE] = conv_irq_en;
                read_word[IRQ_FLAG] = conv_irq_flag;
                read_word[IRQ_STACK_FULL] = stack_full;
            end
            OFS_RESULT: read_word[15:0] = {result_high, result_low};
            default: read_word = RESET_WORD;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            hrdata <= RESET_WORD;
        end else if (pend && !pend_write) begin
            hrdata <= read_word;
        end
    end

    // ========================================
    // Control registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            start_bit <= 1'b0;
            conv_power_en <= 1'b0;
            result_format_sel <= 1'b0;
            ext_channel_sel <= 3'h0;
            input_source_sel <= SRC_EXTERNAL;
            conv_clk_div_sel <= 3'h0;
            ref_source_sel <= 4'h0;
            pin_function_select <= '0;
            ext_ref_input <= 1'b0;
            ref_output_pin <= 1'b0;
            global_irq_en <= 1'b0;
            conv_irq_en <= 1'b0;
        end else if (do_write) begin
            unique case (pend_addr)
                OFS_CTRL0: begin
                    start_bit <= hwdata[CTRL0_START];
                    conv_power_en <= hwdata[CTRL0_POWER];
                    result_format_sel <= hwdata[CTRL0_FORMAT];
                    ext_channel_sel <= hwdata[CTRL0_CH_LSB +: 3];
                end
                OFS_CTRL1: begin
                    input_source_sel <= hwdata[CTRL1_SRC_LSB +: 3];
                    conv_clk_div_sel <= hwdata[CTRL1_DIV_LSB +: 3];
                end
                OFS_CTRL2: ref_source_sel <= hwdata[CTRL2_REF_LSB +: 4];
                OFS_PINSEL: begin
                    pin_function_select <= hwdata[PINS-1:0];
                    ext_ref_input <= hwdata[PINSEL_EXTREF];
                    ref_output_pin <= hwdata[PINSEL_REFOUT];
                end
                OFS_IRQ: begin
                    global_irq_en <= hwdata[IRQ_GLOBAL];
                    conv_irq_en <= hwdata[IRQ_ENABLE];
                end
                default: ;
            endcase
        end
    end

    // ========================================
    // Start pulse: high resets, falling edge launches
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            start_prev <= 1'b0;
        end else begin
            start_prev <= start_bit;
        end
    end

    assign go = start_prev && !start_bit && conv_power_en;
    // Power-down or a held start cancels any running conversion
    assign abort = start_bit || !conv_power_en;

    // ========================================
    // Converter clock divider
    always_ff @(posedge clock) begin
        if (sys_rst || !busy) begin
            div_count <= 7'h00;
        end else if (tick) begin
            div_count <= 7'h00;
        end else begin
            div_count <= div_count + 7'h01;
        end
    end

    // Divide by 2 to the power of the code
    assign tick = (div_count == 7'((8'h01 << conv_clk_div_sel) - 8'h01));

    // Runs on its own; the bus stays free meanwhile
    sar_engine u_sar (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(tick),
        .go(go),
        .abort(abort),
        .comp_high(comp_high),
        .sampling(sampling),
        .busy(busy),
        .done(done),
        .trial(trial),
        .result(code)
    );

    // ========================================
    // Result registers, loaded only at completion
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            result_high <= 8'h00;
            result_low <= 8'h00;
        end else if (done) begin
            if (result_format_sel) begin
                result_high <= {4'h0, code[11:8]};
                result_low <= code[7:0];
            end else begin
                result_high <= code[11:4];
                result_low <= {code[3:0], 4'h0};
            end
        end
    end

    // ========================================
    // Completion request
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            conv_irq_flag <= 1'b0;
        end else if (done) begin
            // Set wins over a same-cycle clear
            conv_irq_flag <= 1'b1;
        end else if (irq_ack) begin
            conv_irq_flag <= 1'b0;
        end else if (do_write && pend_addr == OFS_IRQ) begin
            conv_irq_flag <= hwdata[IRQ_FLAG];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            conv_irq_req <= 1'b0;
        end else begin
            conv_irq_req <= conv_irq_flag && conv_irq_en
                            && global_irq_en
                            && !stack_full && !irq_ack;
        end
    end

    // ========================================
    // Analog side controls
    assign ext_selected = (input_source_sel == SRC_EXTERNAL);

    always_ff @(posedge clock) begin
        if (sys_rst || !conv_power_en) begin
            ana_ctrl <= '0;
        end else begin
            ana_ctrl.power <= 1'b1;
            ana_ctrl.sample <= sampling;
            ana_ctrl.ext_connect <= ext_selected;
            ana_ctrl.channel <= ext_channel_sel;
            ana_ctrl.source <= input_source_sel;
            ana_ctrl.ref_out_en <= ref_output_pin;
            ana_ctrl.dac_code <= trial;
            unique case (ref_source_sel)
                4'h1, 4'h2, 4'h3, 4'h4: begin
                    ana_ctrl.ref_src <= REF_EXT_PIN;
                    ana_ctrl.ref_gain_m1 <= 2'(ref_source_sel - 4'h1);
                end
                4'hA, 4'hB, 4'hC: begin
                    ana_ctrl.ref_src <= REF_BANDGAP;
                    ana_ctrl.ref_gain_m1 <= 2'(ref_source_sel - 4'h9);
                end
                default: begin
                    ana_ctrl.ref_src <= REF_SUPPLY;
                    ana_ctrl.ref_gain_m1 <= 2'h0;
                end
            endcase
        end
    end

    // ========================================
    // Pin sharing, one slice per pin
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        always_ff @(posedge clock) begin
            if (sys_rst) begin
                pad_dout[i] <= 1'b0;
                pad_oe[i] <= 1'b0;
                pad_pull_en[i] <= 1'b0;
                analog_sw_en[i] <= 1'b0;
            end else if (pin_function_select[i]) begin
                pad_dout[i] <= 1'b0;
                pad_oe[i] <= 1'b0;
                pad_pull_en[i] <= 1'b0;
                analog_sw_en[i] <= conv_power_en && ext_selected
                                   && ext_channel_sel == 3'(i);
            end else begin
                pad_dout[i] <= gpio_dout[i];
                pad_oe[i] <= !port_direction_ctrl[i];
                pad_pull_en[i] <= pull_high_req[i];
                analog_sw_en[i] <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

/* File: dv/adc_seq_props.sv */
// Port-level checks on the conversion sequencer.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module adc_seq_props
    import adc_seq_pkg::*;
#(
    parameter int PINS = 8
)(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Bus handshake
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pins
    input wire logic [PINS-1:0] pad_dout,
    input wire logic [PINS-1:0] pad_oe,
    input wire logic [PINS-1:0] pad_pull_en,
    input wire logic [PINS-1:0] analog_sw_en,
    // Analog core and interrupt
    input wire ana_ctrl_s ana_ctrl,
    input wire logic stack_full,
    input wire logic irq_ack,
    input wire logic conv_irq_req
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // ========================================
    // Bus keeps serving while a conversion runs
    chk_bus_okay: assert property (!hresp)
        else $error("not okay");
    chk_ready_pulse: assert property (
        hsel && htrans[1] && hready && hreadyout |=> !hreadyout ##1 hreadyout)
        else $error("ready pulse wrong");

    // ========================================
    // Pin sharing and analog routing
    chk_pin_released: assert property (
        (analog_sw_en & (pad_oe | pad_pull_en | pad_dout)) == '0)
        else $error("analog pin driven");
    chk_switch_onehot: assert property ($onehot0(analog_sw_en))
        else $error("two switches closed");
    chk_switch_power: assert property (
        |analog_sw_en |-> ana_ctrl.power && ana_ctrl.source == SRC_EXTERNAL)
        else $error("switch closed wrongly");
    chk_power_off: assert property (!ana_ctrl.power |-> ana_ctrl == '0)
        else $error("controls live when off");
    chk_ref_valid: assert property (
        ana_ctrl.ref_src != 2'b11 &&
        (ana_ctrl.ref_src != REF_SUPPLY || ana_ctrl.ref_gain_m1 == 2'b00))
        else $error("bad reference");

    // ========================================
    // Sampling phase length
    chk_sample_min: assert property (
        $rose(ana_ctrl.sample) |-> ana_ctrl.sample[*4])
        else $error("sampling too short");
    chk_sample_end: assert property (
        $rose(ana_ctrl.sample) |-> ##[4:600] !ana_ctrl.sample)
        else $error("sampling too long");

    // ========================================
    // Request gating, one cycle late
    chk_irq_stack: assert property ($past(stack_full) |-> !conv_irq_req)
        else $error("request raised with stack full");
    chk_irq_ack: assert property ($past(irq_ack) |-> !conv_irq_req)
        else $error("request through ack");
endmodule

bind adc_conversion_sequencer adc_seq_props #(.PINS(PINS)) u_props (
    .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .pad_dout(pad_dout), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
    .analog_sw_en(analog_sw_en), .ana_ctrl(ana_ctrl),
    .stack_full(stack_full), .irq_ack(irq_ack), .conv_irq_req(conv_irq_req)
);
`default_nettype wire

/* File: dv/analog_input_model.sv */
// Analog input and comparator seen by the sequencer.
// Assumes the bench sets the input level as an ideal code.
`timescale 1ns/1ns
`default_nettype none
module analog_input_model
    import adc_seq_pkg::*;
(
    // Clock
    input wire logic clock,
    // Analog control and level under test
    input wire ana_ctrl_s ana_ctrl,
    input wire logic [RESULT_BITS-1:0] level_code,
    // Comparator
    output logic comp_high
);
    logic last_level = 1'b0;

    // Unpowered output floats: toggle
    always_comb begin
        if (ana_ctrl.power) begin
            comp_high = level_code >= ana_ctrl.dac_code;
        end else begin
            comp_high = ~last_level;
        end
    end

    always @(posedge clock) begin
        last_level <= comp_high;
    end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the conversion sequencer.
// Assumes the analog model answers at once and PINS is 8.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import adc_seq_pkg::*;
    // ========================================
    // Signals
    localparam logic [31:0] ZERO = 32'h0000_0000;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = ZERO;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = ZERO;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [7:0] gpio_dout = 8'hA5;
    logic [7:0] port_direction_ctrl = 8'h0F;
    logic [7:0] pull_high_req = 8'hFF;
    logic [7:0] pad_dout, pad_oe, pad_pull_en, analog_sw_en;
    logic comp_high;
    ana_ctrl_s ana_ctrl;
    logic stack_full = 1'b0;
    logic irq_ack = 1'b0;
    logic conv_irq_req;
    logic [11:0] level_code = 12'h000;
    logic [31:0] rd;
    logic [31:0] last_result = ZERO;
    int mismatches = 0;
    int samples_checked = 0;
    int sample_len = 0;
    int sample_cnt = 0;

    always #2 clock = ~clock;

    adc_conversion_sequencer #(.PINS(8)) dut (
        .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .gpio_dout(gpio_dout),
        .port_direction_ctrl(port_direction_ctrl),
        .pull_high_req(pull_high_req), .pad_dout(pad_dout), .pad_oe(pad_oe),
        .pad_pull_en(pad_pull_en), .analog_sw_en(analog_sw_en),
        .comp_high(comp_high), .ana_ctrl(ana_ctrl), .stack_full(stack_full),
        .irq_ack(irq_ack), .conv_irq_req(conv_irq_req)
    );

    analog_input_model u_model (
        .clock(clock), .ana_ctrl(ana_ctrl), .level_code(level_code),
        .comp_high(comp_high)
    );

    // Last sampling width, system clocks
    always @(posedge clock) begin
        if (ana_ctrl.sample === 1'b1) begin
            sample_cnt <= sample_cnt + 1;
        end else if (sample_cnt != 0) begin
            sample_len <= sample_cnt;
            sample_cnt <= 0;
        end
    end

    // ========================================
    // Shared tasks
    task automatic end_of_test();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wait_ready();
        int n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            mismatches++;
            end_of_test();
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, ZERO);
        check(rd, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic req_is(input logic [31:0] e);
        cyc(3);
        check(32'(conv_irq_req), e);
    endtask

    // ========================================
    // Scenarios
    task automatic test_reset();
        rdchk(OFS_CTRL0, RESET_WORD);
        rdchk(OFS_IRQ, RESET_WORD);
        rdchk(OFS_RESULT, RESET_WORD);
        rdchk(8'h20, ZERO);
    endtask

    task automatic test_pins();
        wr(OFS_PINSEL, 32'h0000_0005);
        cyc(2);
        check(32'(pad_dout), 32'h0000_00A0);
        check(32'(pad_oe), 32'h0000_00F0);
        check(32'(pad_pull_en), 32'h0000_00FA);
        check(32'(analog_sw_en), ZERO);
        wr(OFS_CTRL0, (32'h1 << CTRL0_POWER) | 32'h2);
        cyc(2);
        check(32'(analog_sw_en), 32'h0000_0004);
        wr(OFS_CTRL0, 32'h1 << CTRL0_POWER);
        cyc(2);
        check(32'(analog_sw_en), 32'h0000_0001);
    endtask

    task automatic test_ref();
        logic [1:0] er, eg;
        wr(OFS_PINSEL, 32'h0000_0105);
        for (int c = 0; c < 16; c++) begin
            er = REF_SUPPLY;
            eg = 2'b00;
            if (c >= 1 && c <= 4) begin
                er = REF_EXT_PIN;
                eg = 2'(c - 1);
            end else if (c >= 10 && c <= 12) begin
                er = REF_BANDGAP;
                eg = 2'(c - 9);
            end
            wr(OFS_CTRL2, 32'(c));
            cyc(2);
            check(32'({ana_ctrl.ref_src, ana_ctrl.ref_gain_m1}), 32'({er, eg}));
        end
        wr(OFS_CTRL2, ZERO);
    endtask

    task automatic test_source();
        wr(OFS_PINSEL, ZERO);
        wr(OFS_CTRL1, 32'h3 << CTRL1_SRC_LSB);
        cyc(2);
        check(32'({ana_ctrl.source, ana_ctrl.ext_connect}), 32'h0000_0006);
        check(32'(analog_sw_en), ZERO);
        wr(OFS_CTRL1, ZERO);
        wr(OFS_PINSEL, 32'h0000_0005);
        cyc(2);
        check(32'({ana_ctrl.source, ana_ctrl.ext_connect}), 32'h0000_0001);
    endtask

    task automatic run_conv(input logic [2:0] div, input logic fmt,
                            input logic [11:0] code);
        logic [31:0] ctl;
        int n = 0;
        ctl = (32'h1 << CTRL0_POWER) | (32'(fmt) << CTRL0_FORMAT);
        level_code <= code;
        sample_len = 0;
        wr(OFS_CTRL1, 32'(div));
        wr(OFS_CTRL0, ctl);
        wr(OFS_CTRL0, ctl | (32'h1 << CTRL0_START));
        wr(OFS_CTRL0, ctl);
        rdchk(OFS_CTRL0, ctl | (32'h1 << CTRL0_BUSY));
        rdchk(OFS_RESULT, last_result);
        do begin
            xfer(1'b0, OFS_CTRL0, ZERO);
            n++;
        end while (rd[CTRL0_BUSY] !== 1'b0 && n < 1000);
        if (n >= 1000) begin
            mismatches++;
            end_of_test();
        end
        check(32'(sample_len), 32'h4 << div);
        last_result = fmt ? {20'h0_0000, code} : {16'h0000, code, 4'h0};
        rdchk(OFS_RESULT, last_result);
        rdchk(OFS_IRQ, 32'h1 << IRQ_FLAG);
        req_is(ZERO);
        wr(OFS_IRQ, ZERO);
    endtask

    task automatic test_power_off();
        wr(OFS_CTRL0, ZERO);
        cyc(2);
        check(32'(ana_ctrl), ZERO);
        wr(OFS_CTRL0, 32'h1 << CTRL0_START);
        wr(OFS_CTRL0, ZERO);
        rdchk(OFS_CTRL0, ZERO);
        rdchk(OFS_RESULT, last_result);
        rdchk(OFS_IRQ, ZERO);
    endtask

    task automatic test_irq();
        wr(OFS_IRQ, ZERO);
        wr(OFS_IRQ, 32'h0000_0006);
        req_is(ZERO);
        wr(OFS_IRQ, 32'h0000_0007);
        req_is(32'h0000_0001);
        stack_full <= 1'b1;
        req_is(ZERO);
        rdchk(OFS_IRQ, 32'h0000_000F);
        stack_full <= 1'b0;
        req_is(32'h0000_0001);
        irq_ack <= 1'b1;
        cyc(1);
        irq_ack <= 1'b0;
        req_is(ZERO);
        rdchk(OFS_IRQ, 32'h0000_0003);
    endtask

    // ========================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        test_reset();
        test_pins();
        test_ref();
        test_source();
        for (int d = 0; d < 8; d++) begin
            run_conv(3'(d), d[0], (d == 0) ? 12'hFFF : 12'(d * 529));
        end
        test_power_off();
        test_irq();
        end_of_test();
    end
endmodule
`default_nettype wire
